//--- pirs_slave.v
// Paged register file behind an I2C slave control port
`default_nettype none
`include "pirs_defines.vh"

module pirs_slave
(
  // Clock and reset
  input  wire       clk,
  input  wire       srst,
  // I2C pins
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe,
  // Device-side view
  output reg  [7:0] page_select,
  output wire       broadcast_address_enable,
  output reg        soft_reset_pulse
);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  wire scl;
  wire sda;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  pirs_sync u_sync
  (
    .clk       (clk),
    .srst      (srst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl       (scl),
    .sda       (sda),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Page 0 config plus coefficient pages 2..4, indexed by 0..3
  reg  [7:0] mem [0:4*`PIRS_PAGE_REGS-1];
  reg  [6:0] ptr;
  reg  [7:0] shift;
  reg  [2:0] bit_cnt;
  reg  [2:0] state;
  reg        is_read;
  reg        ptr_loaded;
  reg        shift_done;

  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_AACK  = 3'h2;
  localparam ST_WBYTE = 3'h3;
  localparam ST_WACK  = 3'h4;
  localparam ST_RBYTE = 3'h5;
  localparam ST_RACK  = 3'h6;

  // Storage bank for the active page; reserved pages have none
  // Page 4 lands on bank 3 through the two-bit wrap
  reg [1:0] bank;
  reg       bank_ok;
  always @*
  begin
    bank    = 2'h0;
    bank_ok = 1'b0;
    if (page_select == `PIRS_CFG_PAGE)
      bank_ok = 1'b1;
    else if (page_select >= `PIRS_COEF_PAGE_LO && page_select <= `PIRS_COEF_PAGE_HI)
    begin
      bank    = page_select[1:0] - 2'h1;
      bank_ok = 1'b1;
    end
  end

  wire [8:0] idx = {bank, ptr};
  wire       bcast_sel = mem[`PIRS_REG_SLEEP][`PIRS_BIT_BCAST];
  assign broadcast_address_enable = bcast_sel;

  wire [6:0] my_addr = bcast_sel ? `PIRS_ADDR_BCAST : `PIRS_ADDR_NORMAL;

  // Read data: register 0 always shows the page select
  wire [7:0] rd_data = (ptr == `PIRS_REG_PAGE) ? page_select :
                       (bank_ok ? mem[idx] : 8'h00);

  // Soft reset clears the page select and all register storage the cycle after it is written
  // Engine is left running so the current transfer still ends cleanly
  wire clr_all = srst | soft_reset_pulse;

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  reg        do_write;
  reg  [7:0] wr_byte;
  reg  [6:0] wr_ptr;

  // Open drain: output value fixed low, only the enable moves
  assign sda_out = 1'b0;

  always @(posedge clk)
  begin
    if (srst)
    begin
      state      <= ST_IDLE;
      sda_oe     <= 1'b0;
      bit_cnt    <= 3'h0;
      shift      <= 8'h00;
      is_read    <= 1'b0;
      ptr        <= 7'h00;
      ptr_loaded <= 1'b0;
      do_write   <= 1'b0;
      wr_byte    <= 8'h00;
      wr_ptr     <= 7'h00;
      shift_done <= 1'b0;
    end
    else
    begin
      do_write <= 1'b0;
      if (start_det)
      begin
        // Repeated start keeps the pointer for a following read
        state      <= ST_ADDR;
        bit_cnt    <= 3'h0;
        sda_oe     <= 1'b0;
        shift_done <= 1'b0;
      end
      else if (stop_det)
      begin
        state      <= ST_IDLE;
        sda_oe     <= 1'b0;
        shift_done <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
            sda_oe <= 1'b0;
          ST_ADDR, ST_WBYTE:
          begin
            // Flag, not count: the fall right after a start must not end a byte
            if (scl_rise)
            begin
              shift   <= {shift[6:0], sda};
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7)
                shift_done <= 1'b1;
            end
            if (scl_fall && shift_done)
            begin
              shift_done <= 1'b0;
              if (state == ST_ADDR)
              begin
                if (shift[7:1] == my_addr)
                begin
                  is_read    <= shift[0];
                  ptr_loaded <= 1'b0;
                  sda_oe     <= 1'b1;
                  state      <= ST_AACK;
                end
                else
                  state <= ST_IDLE;
              end
              else
              begin
                if (!ptr_loaded)
                begin
                  ptr        <= shift[6:0];
                  ptr_loaded <= 1'b1;
                end
                else
                begin
                  do_write <= 1'b1;
                  wr_byte  <= shift;
                  wr_ptr   <= ptr;
                  ptr      <= ptr + 7'h1;
                end
                sda_oe <= 1'b1;
                state  <= ST_WACK;
              end
            end
          end
          ST_AACK:
            if (scl_fall)
            begin
              if (is_read)
              begin
                sda_oe  <= ~rd_data[7];
                shift   <= {rd_data[6:0], 1'b0};
                ptr     <= ptr + 7'h1;
                bit_cnt <= 3'h1;
                state   <= ST_RBYTE;
              end
              else
              begin
                sda_oe  <= 1'b0;
                bit_cnt <= 3'h0;
                state   <= ST_WBYTE;
              end
            end
          ST_WACK:
            if (scl_fall)
            begin
              sda_oe  <= 1'b0;
              bit_cnt <= 3'h0;
              state   <= ST_WBYTE;
            end
          ST_RBYTE:
            if (scl_fall)
            begin
              if (bit_cnt == 3'h0)
              begin
                sda_oe <= 1'b0;
                state  <= ST_RACK;
              end
              else
              begin
                sda_oe  <= ~shift[7];
                shift   <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 3'h1;
              end
            end
          ST_RACK:
          begin
            // Master's acknowledge decides whether another byte follows
            if (scl_rise)
              is_read <= ~sda;
            if (scl_fall)
            begin
              if (is_read)
              begin
                sda_oe  <= ~rd_data[7];
                shift   <= {rd_data[6:0], 1'b0};
                ptr     <= ptr + 7'h1;
                bit_cnt <= 3'h1;
                state   <= ST_RBYTE;
              end
              else
                state <= ST_IDLE;
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  integer i;
  always @(posedge clk)
  begin
    if (clr_all)
    begin
      page_select      <= `PIRS_PAGE_RST;
      soft_reset_pulse <= 1'b0;
      for (i = 0; i < 4*`PIRS_PAGE_REGS; i = i + 1)
        mem[i] <= 8'h00;
    end
    else if (do_write)
    begin
      if (wr_ptr == `PIRS_REG_PAGE)
        page_select <= wr_byte;
      else if (page_select == `PIRS_CFG_PAGE && wr_ptr == `PIRS_REG_RESET
               && wr_byte[`PIRS_BIT_SOFTRST])
        soft_reset_pulse <= 1'b1;
      else if (bank_ok)
        mem[{bank, wr_ptr}] <= wr_byte;
    end
  end

endmodule // pirs_slave

`default_nettype wire

//--- pirs_defines.vh
// Constants for the paged I2C register slave
`ifndef PIRS_DEFINES_VH
`define PIRS_DEFINES_VH

`define PIRS_ADDR_NORMAL   7'h4e
`define PIRS_ADDR_BCAST    7'h4c
`define PIRS_REG_PAGE      7'h00
`define PIRS_REG_RESET     7'h01
`define PIRS_REG_SLEEP     7'h02
`define PIRS_BIT_SOFTRST   0
`define PIRS_BIT_BCAST     2
`define PIRS_PAGE_RST      8'h00
`define PIRS_PAGE_REGS     128
`define PIRS_NUM_PAGES     5
`define PIRS_COEF_PAGE_LO  8'h02
`define PIRS_COEF_PAGE_HI  8'h04
`define PIRS_CFG_PAGE      8'h00

`endif

//--- pirs_sync.v
// Two-flop synchroniser with edge detection for the I2C pins
`default_nettype none

module pirs_sync
(
  // Clock and reset
  input  wire clk,
  input  wire srst,
  // Pin levels
  input  wire scl_in,
  input  wire sda_in,
  // Synchronised levels and edges
  output reg  scl,
  output reg  sda,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_det,
  output wire stop_det
);

  reg [1:0] scl_meta;
  reg [1:0] sda_meta;

  always @(posedge clk)
  begin
    if (srst)
    begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl      <= 1'b1;
      sda      <= 1'b1;
    end
    else
    begin
      scl_meta <= {scl_meta[0], scl_in};
      sda_meta <= {sda_meta[0], sda_in};
      scl      <= scl_meta[1];
      sda      <= sda_meta[1];
    end
  end

  assign scl_rise  = ~scl & scl_meta[1];
  assign scl_fall  = scl & ~scl_meta[1];
  // SDA moving while SCL stays high marks a start or stop
  assign start_det = scl & scl_meta[1] & sda & ~sda_meta[1];
  assign stop_det  = scl & scl_meta[1] & ~sda & sda_meta[1];

endmodule // pirs_sync

`default_nettype wire

//--- pirs_props.sv
// Port checker for the paged I2C register slave
`default_nettype none
module pirs_props
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // I2C pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Device side
  input wire logic [7:0] page_select,
  input wire logic       broadcast_address_enable,
  input wire logic       soft_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ----
  // Sequences
  // ----
  sequence oe_up_s; $rose(sda_oe); endsequence
  sequence oe_held_s; sda_oe [*4]; endsequence
  od_low_a: assert property (sda_out == 1'b0)
    else $error("sda data level not low");
  ack_held_a: assert property (oe_up_s |-> oe_held_s)
    else $error("pull dropped early");
  oe_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda moved with scl high");
  bit_stand_a: assert property ($rose(scl_in) |-> $stable(sda_oe) [*4])
    else $error("sda unstable in high phase");
  ack_late_a: assert property (oe_up_s |-> !$past(scl_in) && !$past(scl_in, 2))
    else $error("pull not after scl fall");
  rst_page_a: assert property ($fell(srst) |-> page_select == 8'h00 && !sda_oe)
    else $error("page not zero after reset");
  rst_side_a: assert property ($fell(srst) |-> !broadcast_address_enable && !soft_reset_pulse)
    else $error("side outputs set after reset");
  pulse_one_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  soft_clear_a: assert property (soft_reset_pulse |-> ##[1:2]
    page_select == 8'h00 && !broadcast_address_enable)
    else $error("soft reset left state");
endmodule // pirs_props
`default_nettype wire

//--- pirs_master.sv
// Bus master model for the slave's I2C pins
`default_nettype none
module pirs_master
(
  // Open-drain bus
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QTR = 12;
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start();
    sda_pull = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b0;
    #(2*QTR);
  endtask
  // Nine bits: byte MSB first, then the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_pull = ~tx[i];
      #QTR scl = 1'b1;
      #QTR rx[i] = sda;
      #QTR scl = 1'b0;
      #QTR;
    end
  endtask
endmodule // pirs_master
`default_nettype wire

//--- tb_paged_i2c_register_slave.sv
// Self-checking bench for the paged I2C register slave
`default_nettype none
module tb_paged_i2c_register_slave;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;
  logic       srst;
  logic       scl;
  logic       sda_pull;
  logic       sda;
  logic       sda_out;
  logic       sda_oe;
  logic       bcast;
  logic       pulse;
  logic [7:0] page;
  logic [8:0] rx;
  logic       seen_pulse;
  int         n_mismatch;
  int         checked;
  // Pull-up wins unless someone pulls low
  assign sda = ~(sda_pull | sda_oe);
  pirs_slave DUT (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .page_select(page), .broadcast_address_enable(bcast),
    .soft_reset_pulse(pulse));
  pirs_master m (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  // Remembers that the soft reset strobe went out at least once
  always @(posedge clk)
  begin
    if (srst)
      seen_pulse <= 1'b0;
    else if (pulse)
      seen_pulse <= 1'b1;
  end
  // ----
  // Helpers
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b, input logic a);
    m.xfer({b, 1'b1}, rx);
    check({7'h00, rx[0]}, {7'h00, a});
  endtask
  task automatic rd(input logic [7:0] e, input logic last);
    m.xfer({8'hff, last}, rx);
    check(rx[8:1], e);
  endtask
  task automatic wreg(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
    m.start();
    wr({a, 1'b0}, 1'b0);
    wr(r, 1'b0);
    wr(d, 1'b0);
    m.stop();
    @(negedge clk);
  endtask
  task automatic rreg(input logic [6:0] a, input logic [7:0] r, input logic [7:0] e);
    m.start();
    wr({a, 1'b0}, 1'b0);
    wr(r, 1'b0);
    m.start();
    wr({a, 1'b1}, 1'b0);
    rd(e, 1'b1);
    m.stop();
    @(negedge clk);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic s_burst();
    wreg(7'h4e, 8'h00, 8'h03);
    check(page, 8'h03);
    m.start();
    wr(8'h9c, 1'b0);
    wr(8'h05, 1'b0);
    wr(8'h11, 1'b0);
    wr(8'h22, 1'b0);
    wr(8'h33, 1'b0);
    m.start();
    wr(8'h9c, 1'b0);
    wr(8'h05, 1'b0);
    m.start();
    wr(8'h9d, 1'b0);
    rd(8'h11, 1'b0);
    rd(8'h22, 1'b0);
    rd(8'h33, 1'b1);
    m.stop();
    wreg(7'h4e, 8'h00, 8'h00);
  endtask
  task automatic s_pages();
    wreg(7'h4e, 8'h00, 8'h02);
    wreg(7'h4e, 8'h05, 8'ha5);
    wreg(7'h4e, 8'h00, 8'h04);
    wreg(7'h4e, 8'h05, 8'h5a);
    rreg(7'h4e, 8'h00, 8'h04);
    rreg(7'h4e, 8'h05, 8'h5a);
    wreg(7'h4e, 8'h00, 8'h02);
    rreg(7'h4e, 8'h05, 8'ha5);
    wreg(7'h4e, 8'h00, 8'h03);
    rreg(7'h4e, 8'h05, 8'h11);
    wreg(7'h4e, 8'h00, 8'h00);
    rreg(7'h4e, 8'h05, 8'h00);
  endtask
  task automatic s_addr();
    m.start();
    wr(8'h98, 1'b1);
    m.stop();
    wreg(7'h4e, 8'h02, 8'h04);
    check({7'h00, bcast}, 8'h01);
    m.start();
    wr(8'h9c, 1'b1);
    m.stop();
    wreg(7'h4c, 8'h01, 8'h01);
    check({7'h00, bcast}, 8'h00);
    check({7'h00, seen_pulse}, 8'h01);
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #100us;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    srst = 1'b1;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    repeat (6) @(negedge clk);
    check(page, 8'h00);
    check({7'h00, sda_out}, 8'h00);
    s_burst();
    s_pages();
    s_addr();
    close_out();
  end
endmodule // tb_paged_i2c_register_slave
bind pirs_slave pirs_props chk (.clk(clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .page_select(page_select),
  .broadcast_address_enable(broadcast_address_enable), .soft_reset_pulse(soft_reset_pulse));
`default_nettype wire
